// [rtl/spi_ctrl_top.sv]
// Serial interface control, select pin role and byte shifter on AHB-Lite
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`include "spi_cfg_defs.svh"
module spi_ctrl_top (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic [31:0] HRDATA_O,
  output logic HRESP_O,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_O,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_O,
  input wire logic SS_I,
  output logic SS_O,
  output logic SS_OE_O,
  output logic [1:0] SS_ROLE_O
);
  function automatic logic first_bit(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] v,
                                           input logic lsb);
    return lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Pin synchronisers: sck, mosi, miso, select
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic sck_s3_q;
  logic ss_s3_q;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pin_s1_q <= 4'hF;
      pin_s2_q <= 4'hF;
      sck_s3_q <= 1'b0;
      ss_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= {SCK_I, MOSI_I, MISO_I, SS_I};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= pin_s2_q[3];
      ss_s3_q <= pin_s2_q[0];
    end
  end

  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_s;
  assign sck_s = pin_s2_q[3];
  assign mosi_s = pin_s2_q[2];
  assign miso_s = pin_s2_q[1];
  assign ss_s = pin_s2_q[0];

  // Configuration and decoded fields
  logic [7:0] ctrl_q;
  logic fault_off_q;
  logic done_q;
  logic [7:0] rxbuf_q;
  logic en;
  logic master_role;
  logic auto_ss;
  logic clock_idle_level;
  logic sample_edge_select;
  logic lsb;
  logic [1:0] rate;
  assign en = ctrl_q[`SC_B_EN];
  assign master_role = ctrl_q[`SC_B_MASTER_ROLE];
  assign auto_ss = ctrl_q[`SC_B_AUTO_SS];
  assign clock_idle_level = ctrl_q[`SC_B_CLOCK_IDLE_LEVEL];
  assign sample_edge_select = ctrl_q[`SC_B_SAMPLE_EDGE_SELECT];
  assign lsb = ctrl_q[`SC_B_LSB];
  assign rate = {ctrl_q[`SC_B_RATE_HI], ctrl_q[`SC_B_RATE_LO]};

  // Select pin role
  spi_cfg_pkg::ss_role_e role_d;
  spi_cfg_pkg::ss_role_e role_q;
  assign role_d = !master_role ? spi_cfg_pkg::SS_SLAVE_IN :
                  !fault_off_q ? spi_cfg_pkg::SS_FAULT_IN :
                  auto_ss ? spi_cfg_pkg::SS_AUTO_OUT : spi_cfg_pkg::SS_GPIO;

  // AHB-Lite slave: one wait state per transfer, more while a data write meets a full FIFO
  logic ph_q;
  logic ph_wr_q;
  logic ph_ok_q;
  logic [7:0] ph_idx_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic hresp_q;
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_data;
  logic hit_link;
  logic bus_done;
  logic wr_ctrl;
  logic wr_stat;
  logic [31:0] rd_val;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  assign acc = HSEL_I && HREADY_I && HTRANS_I[1];
  assign hit_ctrl = ph_ok_q && ph_idx_q == `SC_CTRL_IDX;
  assign hit_stat = ph_ok_q && ph_idx_q == `SC_STAT_IDX;
  assign hit_data = ph_ok_q && ph_idx_q == `SC_DATA_IDX;
  assign hit_link = ph_ok_q && ph_idx_q == `SC_LINK_IDX;
  // Full FIFO stretches a data write instead of losing the byte
  assign bus_done = ph_q && !(ph_wr_q && hit_data && !fifo_in_ready);
  assign wr_ctrl = bus_done && ph_wr_q && hit_ctrl;
  assign wr_stat = bus_done && ph_wr_q && hit_stat;

  spi_cfg_pkg::xfer_state_e state_q;
  spi_cfg_pkg::xfer_state_e state_d;
  logic [7:0] stat_val;
  logic [7:0] link_val;
  assign stat_val = {done_q, 3'h0, fault_off_q, 3'h0};
  assign link_val = {3'h0, !fifo_in_ready, !fifo_out_valid,
                     state_q == spi_cfg_pkg::ST_RUN, role_q};
  assign rd_val = hit_ctrl ? {24'h0, ctrl_q} :
                  hit_stat ? {24'h0, stat_val} :
                  hit_data ? {24'h0, rxbuf_q} :
                  hit_link ? {24'h0, link_val} : 32'h0;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ph_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_ok_q <= 1'b0;
      ph_idx_q <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0;
      hresp_q <= 1'b0;
    end else if (acc) begin
      ph_q <= 1'b1;
      ph_wr_q <= HWRITE_I;
      ph_ok_q <= HADDR_I[31:10] == 22'h0 && HADDR_I[1:0] == 2'h0;
      ph_idx_q <= HADDR_I[9:2];
      hready_q <= 1'b0;
    end else if (bus_done) begin
      ph_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= ph_wr_q ? 32'h0 : rd_val;
    end
  end

  // Transfer sequencing shared by master and slave
  logic lat_master_role_q;
  logic lat_clock_idle_level_q;
  logic lat_sample_edge_select_q;
  logic lat_lsb_q;
  logic [1:0] lat_rate_q;
  logic [4:0] edge_q;
  logic [2:0] bits_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic out_q;
  logic sck_q;
  logic tick;
  logic sel;
  logic m_start;
  logic s_start;
  logic start;
  logic abort;
  logic finish;
  logic running;
  logic m_edge;
  logic s_edge;
  logic lead_evt;
  logic trail_evt;
  logic sample_evt;
  logic drive_evt;
  logic in_bit;
  logic byte_done;
  logic [7:0] tx_src;
  logic fifo_pop;

  assign running = state_q == spi_cfg_pkg::ST_RUN;
  assign sel = en && !master_role && !ss_s;
  assign m_start = !running && en && master_role && fifo_out_valid;
  // A slave byte starts at the falling select
  assign s_start = !running && sel && ss_s3_q;
  assign start = m_start || s_start;
  assign abort = running && (!en || master_role != lat_master_role_q ||
                             (!lat_master_role_q && !sel));
  assign finish = running && lat_master_role_q && tick && edge_q == `SC_EDGES;
  // Sixteen edges make eight shift clock cycles
  assign m_edge = running && lat_master_role_q && tick && edge_q != `SC_EDGES;
  assign s_edge = running && !lat_master_role_q && sel && sck_s != sck_s3_q;
  // Leading edge leaves the idle level
  assign lead_evt = m_edge ? !edge_q[0] : s_edge && sck_s3_q == lat_clock_idle_level_q;
  assign trail_evt = m_edge ? edge_q[0] : s_edge && sck_s3_q != lat_clock_idle_level_q;
  assign sample_evt = lat_sample_edge_select_q ? trail_evt : lead_evt;
  assign drive_evt = lat_sample_edge_select_q ? lead_evt : trail_evt;
  assign in_bit = lat_master_role_q ? miso_s : mosi_s;
  assign byte_done = sample_evt && bits_q == 3'h7;
  assign tx_src = fifo_out_valid ? fifo_out_data : 8'h00;
  // Disabled interface drains the FIFO so the bus cannot hang while the block is off
  assign fifo_pop = (start && fifo_out_valid) || !en;
  assign state_d = (abort || finish) ? spi_cfg_pkg::ST_IDLE :
                   start ? spi_cfg_pkg::ST_RUN : state_q;

  sc_rate_div #(.CNT_W(7)) u_div (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .run_i(running && lat_master_role_q),
    .rate_i(lat_rate_q),
    .tick_o(tick)
  );

  sc_fifo #(.WIDTH(8), .DEPTH(`SC_FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(ph_q && ph_wr_q && hit_data),
    .in_ready_o(fifo_in_ready),
    .in_data_i(HWDATA_I[7:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // Registers
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= `SC_CTRL_RST;
      fault_off_q <= 1'b0;
      done_q <= 1'b0;
      rxbuf_q <= 8'h00;
      role_q <= spi_cfg_pkg::SS_SLAVE_IN;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= HWDATA_I[7:0];
      end
      if (wr_stat) begin
        fault_off_q <= HWDATA_I[`SC_B_FAULT_OFF];
      end
      // New completion beats a clear in the same cycle
      done_q <= byte_done || (done_q && !(wr_stat && HWDATA_I[`SC_B_DONE]));
      if (byte_done) begin
        rxbuf_q <= shift_in(rx_q, in_bit, lat_lsb_q);
      end
      role_q <= role_d;
    end
  end

  // Byte shifter; format latched at start
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_q <= spi_cfg_pkg::ST_IDLE;
      lat_master_role_q <= 1'b0;
      lat_clock_idle_level_q <= 1'b0;
      lat_sample_edge_select_q <= 1'b0;
      lat_lsb_q <= 1'b0;
      lat_rate_q <= 2'h0;
      edge_q <= 5'h00;
      bits_q <= 3'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start) begin
        lat_master_role_q <= master_role;
        lat_clock_idle_level_q <= clock_idle_level;
        lat_sample_edge_select_q <= sample_edge_select;
        lat_lsb_q <= lsb;
        lat_rate_q <= rate;
        edge_q <= 5'h00;
        bits_q <= 3'h0;
        // Phase 0 presents the first bit before any edge
        out_q <= sample_edge_select ? out_q : first_bit(tx_src, lsb);
        tx_q <= sample_edge_select ? tx_src : shift_out(tx_src, lsb);
      end else begin
        if (m_edge) begin
          edge_q <= edge_q + 5'h01;
        end
        if (drive_evt) begin
          out_q <= first_bit(tx_q, lat_lsb_q);
          tx_q <= shift_out(tx_q, lat_lsb_q);
        end
        if (sample_evt) begin
          rx_q <= shift_in(rx_q, in_bit, lat_lsb_q);
          bits_q <= bits_q + 3'h1;
        end
      end
    end
  end

  // Pin drivers
  logic sck_oe_q;
  logic mosi_oe_q;
  logic miso_oe_q;
  logic ss_q;
  logic ss_oe_q;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sck_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      ss_q <= 1'b1;
      ss_oe_q <= 1'b0;
    end else begin
      if (m_edge) begin
        sck_q <= !sck_q;
      end else if (!running) begin
        sck_q <= clock_idle_level;
      end
      sck_oe_q <= en && master_role;
      mosi_oe_q <= en && master_role;
      miso_oe_q <= sel;
      // Low for each master byte, high while idle
      ss_q <= !(state_d == spi_cfg_pkg::ST_RUN && lat_master_role_q || m_start);
      ss_oe_q <= en && role_d == spi_cfg_pkg::SS_AUTO_OUT;
    end
  end

  assign HREADYOUT_O = hready_q;
  assign HRDATA_O = hrdata_q;
  assign HRESP_O = hresp_q;
  assign SCK_O = sck_q;
  assign SCK_OE_O = sck_oe_q;
  assign MOSI_O = out_q;
  assign MOSI_OE_O = mosi_oe_q;
  assign MISO_O = out_q;
  assign MISO_OE_O = miso_oe_q;
  assign SS_O = ss_q;
  assign SS_OE_O = ss_oe_q;
  assign SS_ROLE_O = role_q;

  // Helper counters for the assertions
  logic sck_prev_q;
  logic [7:0] sck_gap_q;
  logic [4:0] sck_chg_q;
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sck_prev_q <= 1'b0;
      sck_gap_q <= 8'h00;
      sck_chg_q <= 5'h00;
    end else begin
      sck_prev_q <= SCK_O;
      sck_gap_q <= (SCK_O != sck_prev_q) ? 8'h01 : sck_gap_q + 8'h01;
      sck_chg_q <= start ? 5'h00 :
                   sck_chg_q + 5'((SCK_O != sck_prev_q) && running);
    end
  end

  a_ss_fault_in: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (master_role && !fault_off_q) |=> role_q == spi_cfg_pkg::SS_FAULT_IN && !SS_OE_O)
    else $error("select pin not a fault input");
  a_ss_slave_in: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !master_role |=> role_q == spi_cfg_pkg::SS_SLAVE_IN && !SS_OE_O)
    else $error("select pin not a slave input");
  a_ss_auto_gate: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    SS_OE_O |-> $past(en && master_role && fault_off_q && auto_ss))
    else $error("select driven outside auto mode");
  a_ss_gpio_free: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    role_q == spi_cfg_pkg::SS_GPIO |-> !SS_OE_O)
    else $error("select driven in gpio mode");
  a_ss_auto_level: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (running && lat_master_role_q && $past(running)) |-> !SS_O)
    else $error("select level wrong during byte");
  a_ss_idle_high: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!running && !$past(running) && !$past(m_start)) |-> SS_O)
    else $error("select low while idle");
  a_sck_idle_lvl: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!running && !m_start) |=> SCK_O == $past(clock_idle_level))
    else $error("shift clock idle level wrong");
  a_sck_half_per: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (running && lat_master_role_q && SCK_O != sck_prev_q && edge_q > 5'h01)
    |-> sck_gap_q == 8'((`SC_DIV_MIN / 2) << lat_rate_q))
    else $error("shift clock half period wrong");
  a_eight_cycles: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    finish |-> sck_chg_q == `SC_EDGES)
    else $error("master byte without sixteen edges");
  a_cfg_frozen: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (running && $past(running)) |->
    $stable({lat_clock_idle_level_q, lat_sample_edge_select_q, lat_lsb_q, lat_rate_q}))
    else $error("format changed mid byte");
  a_off_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !en |=> !SCK_OE_O && !MOSI_OE_O && !MISO_OE_O && !SS_OE_O && !running)
    else $error("disabled interface still active");
  a_reset_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $past(SYS_RST_I) |-> ctrl_q == 8'h00 && !running && SS_ROLE_O == 2'h3)
    else $error("control not cleared by reset");
endmodule

// [rtl/spi_cfg_defs.svh]
// Register offsets, field positions, reset values and counts of the block
`ifndef SPI_CFG_DEFS_SVH
`define SPI_CFG_DEFS_SVH

// Register indices; byte address is four times the index
`define SC_CTRL_IDX 8'hF3
`define SC_STAT_IDX 8'hF4
`define SC_DATA_IDX 8'hF5
`define SC_LINK_IDX 8'hF6

`define SC_CTRL_RST 8'h00
`define SC_STAT_RST 8'h00

// serial_control fields
`define SC_B_AUTO_SS 7
`define SC_B_EN 6
`define SC_B_LSB 5
`define SC_B_MASTER_ROLE 4
`define SC_B_CLOCK_IDLE_LEVEL 3
`define SC_B_SAMPLE_EDGE_SELECT 2
`define SC_B_RATE_HI 1
`define SC_B_RATE_LO 0

// serial_status fields
`define SC_B_DONE 7
`define SC_B_FAULT_OFF 3

// link_state fields
`define SC_B_BUSY 2
`define SC_B_FIFO_EMPTY 3
`define SC_B_FIFO_FULL 4

// Divider for rate code 00, shift clock edges per byte, FIFO depth
`define SC_DIV_MIN 16
`define SC_EDGES 5'h10
`define SC_FIFO_DEPTH 8

`endif

// [rtl/spi_cfg_pkg.sv]
// Types shared by the serial interface modules
package spi_cfg_pkg;

  typedef enum logic [1:0] {
    SS_FAULT_IN,
    SS_GPIO,
    SS_AUTO_OUT,
    SS_SLAVE_IN
  } ss_role_e;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } xfer_state_e;

endpackage

// [rtl/sc_fifo.sv]
// Transmit byte FIFO with valid and ready on both sides
module sc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("sc_fifo needs a power-of-two depth of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign fill = wr_q - rd_q;
  assign in_ready_o = fill != FULL_CNT;
  assign out_valid_o = fill != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule

// [rtl/sc_rate_div.sv]
// Half-period tick generator for the master shift clock
`include "spi_cfg_defs.svh"
module sc_rate_div #(
  parameter int CNT_W = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] rate_i,
  output logic tick_o
);
  if (((`SC_DIV_MIN / 2) << 3) > (1 << CNT_W)) begin : g_chk
    $error("sc_rate_div counter too narrow for divide by 128");
  end

  function automatic logic [CNT_W-1:0] half_of(input logic [1:0] r);
    return CNT_W'((`SC_DIV_MIN / 2) << r);
  endfunction

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  // Toggle point every divider/2 cycles
  assign last = half_of(rate_i) - CNT_W'(1);
  assign tick_o = run_i && cnt_q == last;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || tick_o) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
endmodule

// [tb/spi_slave_model.sv]
// External serial slave standing on the far side of the link
module spi_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  input wire logic clock_idle_level_i,
  input wire logic sample_edge_select_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_byte_i,
  output logic miso_o,
  output logic [7:0] rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tx_q;
  int bit_n;

  function automatic logic pick(input int n);
    return lsb_i ? tx_q[n] : tx_q[7-n];
  endfunction

  initial begin
    miso_o = 1'b0;
    rx_byte_o = 8'h00;
    tx_q = 8'h00;
    bit_n = 0;
  end

  // Only a low select opens a byte
  always @(negedge sel_n_i) begin
    tx_q = tx_byte_i;
    bit_n = 0;
    rx_byte_o = 8'h00;
    if (!sample_edge_select_i) begin
      miso_o = pick(0);
    end
  end

  // Released line floats: show the inverse so no stale bit passes
  always @(posedge sel_n_i) begin
    miso_o = ~miso_o;
  end

  // Leading edge leaves the idle level; sample edge follows phase
  always @(sck_i) begin
    if (!sel_n_i && bit_n < 8) begin
      if ((sck_i != clock_idle_level_i) != sample_edge_select_i) begin
        if (lsb_i) begin
          rx_byte_o[bit_n] = mosi_i;
        end else begin
          rx_byte_o[7-bit_n] = mosi_i;
        end
        bit_n++;
      end else begin
        miso_o = pick(bit_n);
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the serial interface control block
`include "spi_cfg_defs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A_CTRL = {22'h0, `SC_CTRL_IDX, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, `SC_STAT_IDX, 2'b00};
  localparam logic [31:0] A_DATA = {22'h0, `SC_DATA_IDX, 2'b00};
  localparam logic [31:0] A_LINK = {22'h0, `SC_LINK_IDX, 2'b00};
  localparam logic [31:0] A_NONE = {22'h0, 8'hF7, 2'b00};
  // Bits: fault off, auto select, master, expected pin role
  localparam logic [4:0] ROLE_TBL [5] = '{5'b01100, 5'b10101, 5'b11110,
    5'b11011, 5'b00011};

  logic clk, rst, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hready, hresp, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic ss_o, ss_oe, miso_m, m_clock_idle_level, m_sample_edge_select, m_lsb;
  logic [31:0] hrdata;
  logic [1:0] ss_role;
  logic [7:0] m_tx, rx_m;
  wire sck_w = sck_oe ? sck_o : m_clock_idle_level;
  wire mosi_w = mosi_oe ? mosi_o : 1'b0;
  wire miso_w = miso_oe ? miso_o : miso_m;
  wire ss_w = ss_oe ? ss_o : 1'b1;
  int error_cnt, total_checks;

  spi_ctrl_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
    .HRDATA_O(hrdata), .HRESP_O(hresp), .SCK_I(sck_w), .SCK_O(sck_o),
    .SCK_OE_O(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE_O(miso_oe), .SS_I(ss_w), .SS_O(ss_o), .SS_OE_O(ss_oe),
    .SS_ROLE_O(ss_role));

  spi_slave_model far_end (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(ss_w),
    .clock_idle_level_i(m_clock_idle_level), .sample_edge_select_i(m_sample_edge_select), .lsb_i(m_lsb), .tx_byte_i(m_tx),
    .miso_o(miso_m), .rx_byte_o(rx_m));

  always #25 clk = ~clk;

  task complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Single AHB transfer; hready is the slave's own ready
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
           output logic [31:0] rdv);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 200);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 200);
    rdv = hrdata;
    if (n >= 200) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] t;
    ahb(1'b1, a, {24'h0, d}, t);
  endtask

  task rd(input logic [31:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask

  task reset_regs;
    logic [31:0] d;
    rd(A_CTRL, d);
    `CHK("ctrl reset", 32'h0, d)
    `CHK("role reset", 2'd3, ss_role)
    `CHK("clock oe reset", 1'b0, sck_oe)
    `CHK("okay resp", 1'b0, hresp)
    wr(A_NONE, 8'hFF);
    rd(A_NONE, d);
    `CHK("unmapped read", 32'h0, d)
    rd(A_CTRL, d);
    `CHK("ctrl untouched", 32'h0, d)
  endtask

  task role_table;
    logic [4:0] t;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      t = ROLE_TBL[i];
      wr(A_STAT, {4'h0, t[4], 3'h0});
      wr(A_CTRL, {t[3], 1'b1, 1'b0, t[2], 4'h0});
      repeat (2) @(posedge clk);
      #1;
      `CHK("pin role", t[1:0], ss_role)
      `CHK("select oe", (t[1:0] == 2'd2), ss_oe)
      `CHK("clock oe", t[2], sck_oe)
      rd(A_LINK, d);
      `CHK("role field", t[1:0], d[1:0])
    end
  endtask

  task xfer(input logic [1:0] rate, input logic clock_idle_level, input logic sample_edge_select,
            input logic lsb, input logic [7:0] tx, input logic [7:0] sx);
    int h, n, tog, first, last;
    logic prev, low_ok, seen;
    logic [31:0] d;
    h = 8 << rate;
    m_clock_idle_level = clock_idle_level;
    m_sample_edge_select = sample_edge_select;
    m_lsb = lsb;
    m_tx = sx;
    wr(A_STAT, 8'h08);
    wr(A_CTRL, {2'b11, lsb, 1'b1, clock_idle_level, sample_edge_select, rate});
    repeat (2) @(posedge clk);
    #1;
    `CHK("idle clock", clock_idle_level, sck_o)
    wr(A_DATA, tx);
    n = 0;
    tog = 0;
    first = 0;
    last = 0;
    seen = 1'b0;
    low_ok = 1'b1;
    prev = sck_o;
    while (!(seen && ss_o === 1'b1) && n < 40 * h) begin
      @(posedge clk);
      #1;
      n++;
      if (ss_o === 1'b0) seen = 1'b1;
      if (sck_o !== prev) begin
        tog++;
        if (tog == 1) first = n;
        last = n;
        if (ss_o !== 1'b0) low_ok = 1'b0;
      end
      prev = sck_o;
    end
    if (n >= 40 * h) begin
      error_cnt++;
      complete_run();
    end
    `CHK("clock edges", 16, tog)
    `CHK("bit period", 15 * h, last - first)
    `CHK("select low", 1'b1, low_ok)
    `CHK("select idle", 1'b1, ss_o)
    `CHK("end idle", clock_idle_level, sck_o)
    `CHK("far rx", tx, rx_m)
    rd(A_DATA, d);
    `CHK("near rx", {24'h0, sx}, d)
    rd(A_STAT, d);
    `CHK("done flag", 1'b1, d[7])
    wr(A_STAT, 8'h88);
  endtask

  // Slowest rate keeps the first byte on the wire while the rest queue
  task fill_drain;
    logic [31:0] d;
    wr(A_CTRL, 8'hD3);
    for (int i = 0; i < 9; i++) begin
      wr(A_DATA, 8'hA0 + 8'(i));
    end
    rd(A_LINK, d);
    `CHK("queue full", 3'b101, {d[4], d[3], d[2]})
    wr(A_CTRL, 8'h93);
    // Disabled block drops one queued byte per cycle
    repeat (10) @(posedge clk);
    #1;
    rd(A_LINK, d);
    `CHK("queue drained", 3'b010, {d[4], d[3], d[2]})
    `CHK("pins off", 3'b000, {sck_oe, mosi_oe, ss_oe})
  endtask

  initial begin
    #(50 * 60000);
    error_cnt++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    m_clock_idle_level = 1'b0;
    m_sample_edge_select = 1'b0;
    m_lsb = 1'b0;
    m_tx = 8'h00;
    error_cnt = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    reset_regs();
    role_table();
    for (int r = 0; r < 4; r++) begin
      xfer(2'(r), r[0], r[1], r[0] ^ r[1], 8'hC1 ^ 8'(r), 8'h2B ^ 8'(r << 4));
    end
    fill_drain();
    complete_run();
  end
endmodule
